// File: inc/route_cfg_pkg.sv
// What this block does
// RULE1: eight-bit read/write register at address 03h, whole register resets to 00h
// RULE2: bits 7:5 route source one: off, inputs 0-3, positive, negative reference
// RULE3: bits 4:2 route source two with the same encoding as source one
// RULE4: bit 1 set also shows data ready on the shared data-out pin
// RULE5: bit 0 is reserved, stored and read back, master writes zero
// RULE6: serial port runs in mode 1, clock polarity 0, clock phase 1
// RULE7: serial clock idles low, output data changes only on rising edges
// RULE8: incoming serial data is sampled on falling serial clock edges
// RULE9: both source magnitudes come from register 2 bits 2:0
// RULE10: master reads a result with 16 rising edges while select is low
package route_cfg_pkg;

    // register map
    localparam int REG_COUNT = 4;
    localparam logic [1:0] MAGNITUDE_ADDR = 2'h2;
    localparam logic [1:0] ROUTE_ADDR = 2'h3;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int MAG_MSB = 2;
    localparam logic [2:0] MAG_OFF = 3'h0;

    // route codes
    localparam logic [2:0] ROUTE_OFF = 3'h0;
    localparam logic [2:0] ROUTE_LAST = 3'h6;
    localparam int PIN_COUNT = 6;
    localparam int SOURCE_COUNT = 2;

    // serial commands, upper nibble of the command byte
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_READ = 4'h2;
    localparam logic [3:0] BYTE_LAST = 4'h7;
    localparam logic [3:0] WORD_LAST = 4'hF;
    localparam int WORD_WIDTH = 16;

    // frame phase
    typedef enum logic [4:0] {
        PH_FIRST = 5'h01,
        PH_DATA = 5'h02,
        PH_CMD = 5'h04,
        PH_WDATA = 5'h08,
        PH_RDATA = 5'h10
    } phase_t;

    // field layout of the routing register
    typedef struct packed {
        logic [2:0] firstRoute;
        logic [2:0] secondRoute;
        logic readyShared;
        logic reserved;
    } route_cfg_t;

    // one register write handed across domains
    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] data;
    } reg_write_t;

endpackage

// File: sim/current_route_ready_config_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin errors++; \
    $display("[ERR] %s exp %h got %h", nm, e, a); end end
module current_route_ready_config_bench;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic sclk, csN, din, doutPin, doutOeN, readyPinN;
    logic sampleValid = 1'b0;
    logic [15:0] sampleData = 16'h0000;
    logic [5:0] firstPinEnable, secondPinEnable;
    logic [2:0] currentMagnitude, code, mag;
    route_cfg_pkg::route_cfg_t routeCfg;
    int errors = 0;
    int n_compared = 0;
    logic [31:0] expQ[$];
    logic [31:0] nt;
    logic [7:0] cfg;
    event got;
    current_route_ready_config u_dut (.clk(clk), .resetn(resetn), .sclk(sclk),
        .csN(csN), .din(din), .doutPin(doutPin), .doutOeN(doutOeN),
        .readyPinN(readyPinN), .sampleValid(sampleValid),
        .sampleData(sampleData), .firstPinEnable(firstPinEnable),
        .secondPinEnable(secondPinEnable),
        .currentMagnitude(currentMagnitude), .routeCfg(routeCfg));
    spi_master_model u_m (.sclk(sclk), .csN(csN), .din(din),
        .doutPin(doutPin));
    ////////////////////////////////////////////////////////////////////////
    // 250 MHz clock
    initial begin
        forever #2 clk = ~clk;
    end
    function automatic logic [5:0] oneHot(input logic [2:0] c);
        return (c == 3'h0 || c == 3'h7) ? 6'h00 : 6'h01 << (c - 3'h1);
    endfunction
    // one frame writes magnitude then routing register
    task automatic wr(input logic [2:0] mag, input logic [7:0] v);
        u_m.sel(1'b1);
        u_m.shift(24, {8'h49, 5'h00, mag, v});
        u_m.sel(1'b0);
        repeat (8) @(posedge clk);
    endtask
    // an ignored command, then read back registers 2 and 3 together
    task automatic rd(input logic [2:0] mag, input logic [7:0] v);
        expQ.push_back({16'hFFFF, 5'h00, mag, v});
        u_m.sel(1'b1);
        u_m.shift(32, {8'h0C, 8'h29, 16'($urandom)});
        u_m.sel(1'b0);
        -> got;
    endtask
    task automatic summarize();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // compare each serial result with the oldest note
    initial begin
        forever begin
            @(got);
            nt = expQ.pop_front();
            `CHK("serial", nt[15:0], u_m.rx[15:0] & nt[31:16])
        end
    end
    initial begin
        #200000;
        errors++;
        summarize();
    end
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        void'($urandom(70116));
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK("cfgReset", 8'h00, routeCfg)
        `CHK("readyReset", 1'b1, readyPinN)
        rd(3'h0, 8'h00);
        $display("test reset done");
        for (int c = 0; c < 8; c++) begin
            code = c[2:0];
            mag = 3'($urandom_range(7, 1));
            cfg = {code, ~code, 1'($urandom), 1'b0};
            wr(mag, cfg);
            `CHK("cfg", cfg, routeCfg)
            `CHK("first", oneHot(code), firstPinEnable)
            `CHK("second", oneHot(~code), secondPinEnable)
            rd(mag, cfg);
        end
        wr(3'h0, 8'h24);
        `CHK("gated", 6'h00, firstPinEnable)
        `CHK("gated2", 6'h00, secondPinEnable)
        u_m.sel(1'b1);
        `CHK("sharedOff", 1'b0, doutPin)
        u_m.sel(1'b0);
        $display("test routing done");
        wr(3'h5, 8'h26);
        `CHK("mag", 3'h5, currentMagnitude)
        u_m.sel(1'b1);
        `CHK("sharedIdle", 1'b1, doutPin)
        u_m.sel(1'b0);
        @(posedge clk);
        sampleData <= 16'($urandom);
        sampleValid <= 1'b1;
        @(posedge clk);
        sampleValid <= 1'b0;
        @(posedge clk);
        `CHK("ready", 1'b0, readyPinN)
        expQ.push_back({16'hFFFF, sampleData});
        u_m.sel(1'b1);
        `CHK("shared", 1'b0, doutPin)
        u_m.shift(16, 32'($urandom));
        u_m.sel(1'b0);
        -> got;
        repeat (4) @(posedge clk);
        `CHK("readyDone", 1'b1, readyPinN)
        $display("test ready done");
        summarize();
    end
endmodule

// File: sim/route_cfg_props.sv
`timescale 1ns/1ps
module route_cfg_props (
    input wire logic clk,
    input wire logic resetn,
    input wire logic sclk,
    input wire logic csN,
    input wire logic doutPin,
    input wire logic doutOeN,
    input wire logic readyPinN,
    input wire logic sampleValid,
    input wire logic [5:0] firstPinEnable,
    input wire logic [5:0] secondPinEnable,
    input wire logic [2:0] currentMagnitude,
    input route_cfg_pkg::route_cfg_t routeCfg
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////
    // both register fields unchanged over the last cycle
    sequence s_settled;
        $stable(routeCfg) && $stable(currentMagnitude);
    endsequence
    property p_oe;
        doutOeN == csN;
    endproperty
    property p_reset;
        $rose(resetn) |-> routeCfg == 8'h00 && readyPinN && !firstPinEnable;
    endproperty
    property p_ready_set;
        sampleValid |=> !readyPinN;
    endproperty
    property p_ready_cause;
        $fell(readyPinN) |-> $past(sampleValid);
    endproperty
    property p_first_on;
        s_settled ##0 currentMagnitude != 3'h0 &&
            routeCfg.firstRoute inside {[3'h1:3'h6]}
            |-> firstPinEnable == 6'h01 << (routeCfg.firstRoute - 3'h1);
    endproperty
    property p_second_on;
        s_settled ##0 currentMagnitude != 3'h0 &&
            routeCfg.secondRoute inside {[3'h1:3'h6]}
            |-> secondPinEnable == 6'h01 << (routeCfg.secondRoute - 3'h1);
    endproperty
    property p_mag_gate;
        s_settled ##0 currentMagnitude == 3'h0
            |-> firstPinEnable == 6'h00 && secondPinEnable == 6'h00;
    endproperty
    // output holds while select stays low, the serial clock stays in one phase and ready is stable
    property p_dout;
        !csN && $past(!csN) && sclk == $past(sclk) && $stable(readyPinN)
            |-> $stable(doutPin);
    endproperty
    a_oe: assert property (p_oe) else $error("oe vs select");
    a_reset: assert property (p_reset) else $error("reset value");
    a_ready_set: assert property (p_ready_set) else $error("ready");
    a_ready_cause: assert property (p_ready_cause) else $error("rdy");
    a_first_on: assert property (p_first_on) else $error("first");
    a_second_on: assert property (p_second_on) else $error("second");
    a_mag_gate: assert property (p_mag_gate) else $error("gate");
    a_dout: assert property (p_dout) else $error("dout moved");
endmodule
bind current_route_ready_config route_cfg_props u_props (.clk(clk),
    .resetn(resetn), .sclk(sclk), .csN(csN), .doutPin(doutPin),
    .doutOeN(doutOeN), .readyPinN(readyPinN), .sampleValid(sampleValid),
    .firstPinEnable(firstPinEnable), .secondPinEnable(secondPinEnable),
    .currentMagnitude(currentMagnitude), .routeCfg(routeCfg));

// File: sim/spi_master_model.sv
`timescale 1ns/1ps
module spi_master_model (
    output logic sclk,
    output logic csN,
    output logic din,
    input wire logic doutPin
);
    logic [31:0] rx;
    // clock idles low between frames
    initial begin
        sclk = 1'b0;
        csN = 1'b1;
        din = 1'b0;
    end
    // select or release; a released data line flips
    task automatic sel(input logic on);
        #10.3;
        csN = !on;
        if (!on) din = !din;
        #10;
    endtask
    // mode 1: launch on rise, sample on fall, msb first
    task automatic shift(input int n, input logic [31:0] tx);
        for (int i = n - 1; i >= 0; i--) begin
            sclk = 1'b1;
            din = tx[i];
            #7.5;
            sclk = 1'b0;
            rx = {rx[30:0], doutPin};
            #7.5;
        end
    endtask
endmodule

// File: verilog/current_route_ready_config.sv
`timescale 1ns/1ps
module current_route_ready_config (
    input wire logic clk,
    input wire logic resetn,
    input wire logic sclk,
    input wire logic csN,
    input wire logic din,
    output logic doutPin,
    output logic doutOeN,
    output logic readyPinN,
    input wire logic sampleValid,
    input wire logic [15:0] sampleData,
    output logic [5:0] firstPinEnable,
    output logic [5:0] secondPinEnable,
    output logic [2:0] currentMagnitude,
    output route_cfg_pkg::route_cfg_t routeCfg
);
    ////////////////////////////////////////////////////////////////////////
    // declarations
    logic [7:0] cfgRegs [route_cfg_pkg::REG_COUNT];
    logic [15:0] convWord;
    logic frameRstN;
    route_cfg_pkg::phase_t phase;
    route_cfg_pkg::phase_t ph;
    logic [3:0] bitCount;
    logic [6:0] rxShift;
    logic [7:0] rxByte;
    logic [1:0] addrPtr;
    logic [1:0] remain;
    logic [7:0] txByte;
    logic doutBit;
    logic launched;
    logic byteDone;
    logic wordDone;
    logic wrEvent;
    logic doneEvent;
    logic wrToggle;
    logic doneToggle;
    route_cfg_pkg::reg_write_t wrHold;
    logic wrPulse;
    logic donePulse;
    logic [1:0][5:0] pinEnable;

    ////////////////////////////////////////////////////////////////////////
    // link domain: serial clock; all but the event toggles and the held write word cleared while select is high

    // frame logic restarts with every select assertion
    assign frameRstN = resetn & ~csN;
    // at the first bit the ready flag decides: pending result is shifted out, else command
    assign ph = (phase == route_cfg_pkg::PH_FIRST) ?
        (readyPinN ? route_cfg_pkg::PH_CMD : route_cfg_pkg::PH_DATA) : phase;
    assign rxByte = {rxShift, din};
    assign byteDone = (bitCount == route_cfg_pkg::BYTE_LAST);
    assign wordDone = (bitCount == route_cfg_pkg::WORD_LAST);
    assign wrEvent = (ph == route_cfg_pkg::PH_WDATA) && byteDone;
    assign doneEvent = (ph == route_cfg_pkg::PH_DATA) && wordDone;

    // receive side: sample on falling edges and decode commands
    always_ff @(negedge sclk or negedge frameRstN) begin // RULE8 RULE6
        if (!frameRstN) begin
            phase <= route_cfg_pkg::PH_FIRST;
            bitCount <= 4'h0;
            rxShift <= 7'h00;
            addrPtr <= 2'h0;
            remain <= 2'h0;
            txByte <= 8'h00;
        end else begin
            case (ph)
                route_cfg_pkg::PH_DATA: begin
                    if (wordDone) begin // RULE10
                        phase <= route_cfg_pkg::PH_CMD;
                        bitCount <= 4'h0;
                    end else begin
                        phase <= route_cfg_pkg::PH_DATA;
                        bitCount <= bitCount + 4'h1;
                    end
                end
                route_cfg_pkg::PH_CMD: begin
                    rxShift <= rxByte[6:0];
                    if (!byteDone) begin
                        phase <= ph;
                        bitCount <= bitCount + 4'h1;
                    end else begin
                        bitCount <= 4'h0;
                        addrPtr <= rxByte[3:2];
                        remain <= rxByte[1:0];
                        if (rxByte[7:4] == route_cfg_pkg::CMD_WRITE) begin
                            phase <= route_cfg_pkg::PH_WDATA;
                        end else if (rxByte[7:4] == route_cfg_pkg::CMD_READ) begin
                            phase <= route_cfg_pkg::PH_RDATA;
                            txByte <= cfgRegs[rxByte[3:2]];
                        end else begin
                            phase <= route_cfg_pkg::PH_CMD;
                        end
                    end
                end
                route_cfg_pkg::PH_WDATA: begin
                    rxShift <= rxByte[6:0];
                    if (!byteDone) begin
                        phase <= ph;
                        bitCount <= bitCount + 4'h1;
                    end else begin
                        bitCount <= 4'h0;
                        addrPtr <= addrPtr + 2'h1;
                        remain <= remain - 2'h1;
                        phase <= (remain == 2'h0) ? route_cfg_pkg::PH_CMD
                            : route_cfg_pkg::PH_WDATA;
                    end
                end
                route_cfg_pkg::PH_RDATA: begin
                    rxShift <= rxByte[6:0];
                    if (!byteDone) begin
                        phase <= ph;
                        bitCount <= bitCount + 4'h1;
                    end else begin
                        bitCount <= 4'h0;
                        if (remain == 2'h0) begin
                            phase <= route_cfg_pkg::PH_CMD;
                        end else begin
                            phase <= route_cfg_pkg::PH_RDATA;
                            addrPtr <= addrPtr + 2'h1;
                            remain <= remain - 2'h1;
                            txByte <= cfgRegs[addrPtr + 2'h1];
                        end
                    end
                end
                default: begin
                    phase <= route_cfg_pkg::PH_CMD;
                    bitCount <= 4'h0;
                end
            endcase
        end
    end

    // events to the system domain; toggles survive select going high
    always_ff @(negedge sclk or negedge resetn) begin
        if (!resetn) begin
            wrToggle <= 1'b0;
            doneToggle <= 1'b0;
            wrHold <= '0;
        end else begin
            if (wrEvent) begin
                wrHold.addr <= addrPtr;
                wrHold.data <= rxByte;
                wrToggle <= ~wrToggle;
            end
            if (doneEvent) begin
                doneToggle <= ~doneToggle;
            end
        end
    end

    // transmit side: launch the next bit on rising edges only
    always_ff @(posedge sclk or negedge frameRstN) begin // RULE7 RULE6
        if (!frameRstN) begin
            doutBit <= 1'b0;
        end else if (ph == route_cfg_pkg::PH_DATA) begin
            doutBit <= convWord[route_cfg_pkg::WORD_LAST - bitCount];
        end else if (ph == route_cfg_pkg::PH_RDATA) begin
            doutBit <= txByte[3'(route_cfg_pkg::BYTE_LAST - bitCount)];
        end else begin
            doutBit <= 1'b0;
        end
    end

    // marks the first rising edge of a frame; the mirror must end there,
    // or the master would sample ready instead of the first result bit
    always_ff @(posedge sclk or negedge frameRstN) begin // RULE7
        if (!frameRstN) begin
            launched <= 1'b0;
        end else begin
            launched <= 1'b1;
        end
    end

    // shared pin: before the first clock it mirrors ready when enabled
    assign doutPin = (!launched && routeCfg.readyShared)
        ? readyPinN : doutBit; // RULE4
    assign doutOeN = csN;

    ////////////////////////////////////////////////////////////////////////
    // system domain

    toggle_sync u_wr_sync (
        .clk(clk),
        .resetn(resetn),
        .toggleIn(wrToggle),
        .pulse(wrPulse)
    );

    toggle_sync u_done_sync (
        .clk(clk),
        .resetn(resetn),
        .toggleIn(doneToggle),
        .pulse(donePulse)
    );

    // register file; held write word is stable for a whole byte time
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < route_cfg_pkg::REG_COUNT; i++) begin
                cfgRegs[i] <= route_cfg_pkg::REG_RESET; // RULE1
            end
        end else if (wrPulse) begin
            cfgRegs[wrHold.addr] <= wrHold.data; // RULE1 RULE5
        end
    end

    // result latch and ready flag; a new sample wins over a finished read
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            convWord <= 16'h0000;
            readyPinN <= 1'b1;
        end else if (sampleValid) begin
            convWord <= sampleData;
            readyPinN <= 1'b0;
        end else if (donePulse) begin
            readyPinN <= 1'b1;
        end
    end

    // configuration outputs straight from the register flops
    assign routeCfg = route_cfg_pkg::route_cfg_t'(
        cfgRegs[route_cfg_pkg::ROUTE_ADDR]); // RULE2 RULE3 RULE4 RULE5
    assign currentMagnitude =
        cfgRegs[route_cfg_pkg::MAGNITUDE_ADDR][route_cfg_pkg::MAG_MSB:0];

    current_router u_router (
        .clk(clk),
        .resetn(resetn),
        .cfg(routeCfg),
        .magnitude(currentMagnitude),
        .pinEnable(pinEnable)
    );

    assign firstPinEnable = pinEnable[0];
    assign secondPinEnable = pinEnable[1];
endmodule

// File: verilog/current_router.sv
`timescale 1ns/1ps
module current_router (
    input wire logic clk,
    input wire logic resetn,
    input route_cfg_pkg::route_cfg_t cfg,
    input wire logic [2:0] magnitude,
    output logic [route_cfg_pkg::SOURCE_COUNT-1:0][route_cfg_pkg::PIN_COUNT-1:0]
        pinEnable
);
    genvar s;
    generate
        for (s = 0; s < route_cfg_pkg::SOURCE_COUNT; s++) begin : g_src
            logic [2:0] code;
            // source 0 takes bits 7:5, source 1 bits 4:2
            assign code = (s == 0) ? cfg.firstRoute : cfg.secondRoute;
            // one-hot pin switch; off and the unused code close nothing
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    pinEnable[s] <= '0;
                end else begin
                    pinEnable[s] <= '0;
                    if (code != route_cfg_pkg::ROUTE_OFF &&
                        code <= route_cfg_pkg::ROUTE_LAST &&
                        magnitude != route_cfg_pkg::MAG_OFF) begin // RULE9
                        pinEnable[s][code - 3'h1] <= 1'b1; // RULE2 RULE3
                    end
                end
            end
        end
    endgenerate
endmodule

// File: verilog/toggle_sync.sv
`timescale 1ns/1ps
module toggle_sync (
    input wire logic clk,
    input wire logic resetn,
    input wire logic toggleIn,
    output logic pulse
);
    logic sync1;
    logic sync2;
    logic sync3;

    // two-stage synchroniser, then edge detect on the settled stages
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
            pulse <= 1'b0;
        end else begin
            sync1 <= toggleIn;
            sync2 <= sync1;
            sync3 <= sync2;
            pulse <= sync2 ^ sync3;
        end
    end
endmodule
